// *** logic/acs_top.sv ***
// Conversion sequencer top: APB register file, sequencer and request routing.
// Assumes an external comparator on cmp_in and a transfer controller on xfer_ack.
//
// Function
// - Ten approximation steps, left-aligned 16-bit result
// - Go bit starts single conversion, self-clears
// - Completion sets done flag, request if enabled
// - Controller service clears done flag automatically
// - CPU clears done only after reading status
// - One write sets mode, rate, inputs, go
// - Single end: store result, flag, clear go
// - Setting go again repeats single conversion
// - Scan starts at group first input
// - Next scan input follows a fixed gap, no sync delay
// - Scan repeats cyclically until go cleared
// - Scan flags done once per full sweep
// - Sync delay, then sampling window, then steps
// - Sync delay varies with rate selection
// - First conversion takes documented total states
// - Later scan conversions take fixed states
// - Transfer enable routes request to controller
// - Control/status field layout, reset zero
// - Four result words shared by two groups
// - Result read latches low byte in holder
// - Ten bits in top, low six zero
`timescale 1ns/100ps
module acs_top
    import acs_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              standby,
    input  wire logic              cmp_in,
    input  wire logic              xfer_ack,
    output logic      [9:0]        dac_code,
    output logic                   sample_hold,
    output logic      [2:0]        input_sel,
    output logic                   converting,
    output logic                   conversion_done_request,
    output logic                   xfer_request
);
    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_CSR  = 3'h1;
    localparam logic [2:0] SEL_TEN  = 3'h2;
    localparam logic [2:0] SEL_RES  = 3'h3;
    localparam logic [2:0] SEL_HOLD = 3'h4;

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = a[ADDR_W-1:2];
        if (a[1:0] != 2'b00) begin
            return SEL_NONE;
        end
        if (idx == IDX_CSR) begin
            return SEL_CSR;
        end
        if (idx == IDX_TEN) begin
            return SEL_TEN;
        end
        if (idx == IDX_HOLD) begin
            return SEL_HOLD;
        end
        if (idx[15:2] == IDX_RES_BASE[15:2]) begin
            return SEL_RES;
        end
        return SEL_NONE;
    endfunction : reg_sel

    acs_if cif ();

    logic        done;
    logic        irq_en;
    logic        go;
    logic        scan;
    logic        conversion_rate_select;
    logic [2:0]  chan;
    logic        ten;
    logic        read_seen;
    logic [7:0]  hold;
    logic [3:0]  div;
    logic [5:0]  cnt;
    logic [2:0]  cur_ch;
    logic        cmp_meta;
    logic        cmp_sync;
    acs_state_e  state;
    acs_state_e  next_state;

    wire  [2:0]  sel      = reg_sel(paddr);
    wire         access   = psel && penable;
    wire         finish   = access && pready;
    wire         wr_ok    = finish && pwrite && (sel != SEL_NONE);
    wire         rd_ok    = finish && !pwrite;
    wire         lane0    = pstrb[0];
    wire         csr_wr   = wr_ok && (sel == SEL_CSR) && lane0;
    wire         ten_wr   = wr_ok && (sel == SEL_TEN) && lane0;
    wire  [7:0]  csr_byte = {done, irq_en, go, scan, conversion_rate_select, chan};

    // ------------------------------------------------------------------
    // Sequencer decode
    // ------------------------------------------------------------------
    wire         stop      = standby || !go;
    wire         tick      = (cnt == 6'h01);
    wire  [2:0]  first_ch  = {chan[CSR_GRP], 2'b00};
    wire         last_ch   = (cur_ch == chan);
    wire         conv_end  = (state == ACS_FINISH) && tick && !stop;
    wire         sweep_end = conv_end && (!scan || last_ch);
    wire         single_end = conv_end && !scan;
    wire  [5:0]  sync_len  = conversion_rate_select ? (SYNC_BASE_FAST + {3'b000, SYNC_SPAN_FAST - div[2:0]})
                                 : (SYNC_BASE_SLOW + {2'b00, SYNC_SPAN_SLOW - div});
    wire  [5:0]  samp_len  = conversion_rate_select ? SAMP_LEN_FAST : SAMP_LEN_SLOW;
    wire  [5:0]  fin_len   = conversion_rate_select ? FIN_LEN_FAST : FIN_LEN_SLOW;
    wire  [5:0]  gap_len   = conversion_rate_select ? GAP_LEN_FAST : GAP_LEN_SLOW;
    wire         go_set    = csr_wr && pwdata[CSR_GO];
    wire         done_clr_cpu = csr_wr && !pwdata[CSR_DONE] && read_seen;
    wire         done_clr_xfer = xfer_ack && ten;

    assign cif.ce       = ce;
    assign cif.start    = (state == ACS_SAMPLE) && tick && !stop;
    assign cif.abort    = stop;
    assign cif.step_len = conversion_rate_select ? STEP_LEN_FAST : STEP_LEN_SLOW;
    assign cif.cmp      = cmp_sync;
    assign cif.clr      = standby;
    assign cif.wr_en    = conv_end;
    assign cif.wr_slot  = cur_ch[1:0];
    assign cif.wr_data  = {cif.sar_result, {RES_PAD{1'b0}}};
    assign cif.rd_slot  = paddr[3:2];

    acs_sar u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .s       (cif.sar)
    );

    acs_result_mem u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .m       (cif.mem)
    );

    // ------------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (sel)
            SEL_CSR:  rd_mux = {24'h000000, csr_byte};
            SEL_TEN:  rd_mux = {31'h00000000, ten};
            SEL_RES:  rd_mux = {16'h0000, cif.rd_data};
            SEL_HOLD: rd_mux = {24'h000000, hold};
            default:  rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            pready  <= access && !pready;
            pslverr <= access && !pready && (sel == SEL_NONE);
            if (access && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control and status bits
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= CSR_RESET[CSR_IE];
            scan   <= CSR_RESET[CSR_SCAN];
            conversion_rate_select    <= CSR_RESET[CSR_CKS];
            chan   <= CSR_RESET[2:0];
            ten    <= 1'b0;
        end else if (ce) begin
            if (standby) begin
                irq_en <= CSR_RESET[CSR_IE];
                scan   <= CSR_RESET[CSR_SCAN];
                conversion_rate_select    <= CSR_RESET[CSR_CKS];
                chan   <= CSR_RESET[2:0];
            end else if (csr_wr) begin
                irq_en <= pwdata[CSR_IE];
                scan   <= pwdata[CSR_SCAN];
                conversion_rate_select    <= pwdata[CSR_CKS];
                chan   <= pwdata[2:0];
            end
            if (ten_wr) begin
                ten <= pwdata[TEN_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go <= CSR_RESET[CSR_GO];
        end else if (ce) begin
            if (standby) begin
                go <= 1'b0;
            end else if (go_set) begin
                go <= 1'b1;
            end else if (csr_wr) begin
                go <= 1'b0;
            end else if (single_end) begin
                go <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done      <= CSR_RESET[CSR_DONE];
            read_seen <= 1'b0;
        end else if (ce) begin
            if (standby) begin
                done      <= 1'b0;
                read_seen <= 1'b0;
            end else if (sweep_end) begin
                done      <= 1'b1;
                read_seen <= 1'b0;
            end else if (done_clr_cpu || done_clr_xfer) begin
                done      <= 1'b0;
                read_seen <= 1'b0;
            end else if (rd_ok && (sel == SEL_CSR) && done) begin
                read_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= HOLD_RESET;
        end else if (ce) begin
            if (standby) begin
                hold <= HOLD_RESET;
            end else if (rd_ok && (sel == SEL_RES)) begin
                hold <= cif.rd_data[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ACS_IDLE:    next_state = go ? ACS_SYNC : ACS_IDLE;
            ACS_SYNC:    next_state = tick ? ACS_SAMPLE : ACS_SYNC;
            ACS_SAMPLE:  next_state = tick ? ACS_CONVERT : ACS_SAMPLE;
            ACS_CONVERT: next_state = cif.sar_done ? ACS_FINISH : ACS_CONVERT;
            ACS_FINISH:  next_state = tick ? (scan ? ACS_GAP : ACS_IDLE) : ACS_FINISH;
            ACS_GAP:     next_state = tick ? ACS_SAMPLE : ACS_GAP;
            default:     next_state = ACS_IDLE;
        endcase
        if (stop) begin
            next_state = ACS_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= ACS_IDLE;
            cnt    <= 6'h00;
            cur_ch <= 3'h0;
            div    <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            div   <= div + 4'h1;
            if (state == ACS_IDLE) begin
                cnt    <= sync_len - 6'h01;
                cur_ch <= scan ? first_ch : chan;
            end else if (state == ACS_CONVERT) begin
                cnt <= fin_len - 6'h01;
            end else if (!tick) begin
                cnt <= cnt - 6'h01;
            end else if (state == ACS_FINISH) begin
                cnt    <= gap_len;
                cur_ch <= last_ch ? first_ch : cur_ch + 3'h1;
            end else begin
                cnt <= samp_len;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pins and requests
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_meta                <= 1'b0;
            cmp_sync                <= 1'b0;
            dac_code                <= 10'h000;
            sample_hold             <= 1'b0;
            input_sel               <= 3'h0;
            converting              <= 1'b0;
            conversion_done_request <= 1'b0;
            xfer_request            <= 1'b0;
        end else if (ce) begin
            cmp_meta                <= cmp_in;
            cmp_sync                <= cmp_meta;
            dac_code                <= cif.sar_trial;
            sample_hold             <= (state == ACS_SAMPLE);
            input_sel               <= cur_ch;
            converting              <= (state != ACS_IDLE);
            conversion_done_request <= done && irq_en && !ten;
            xfer_request            <= done && irq_en && ten;
        end
    end
endmodule : acs_top

// *** include/acs_pkg.sv ***
// Constants, register map and sequencer states of the conversion sequencer.
// Assumes one state of the converter equals one pclk cycle.
package acs_pkg;

    // ------------------------------------------------------------------
    // Register map (word index, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 18;
    localparam logic [15:0] IDX_CSR      = 16'hffe8;
    localparam logic [15:0] IDX_TEN      = 16'hfff7;
    localparam logic [15:0] IDX_RES_BASE = 16'hffe0;
    localparam logic [15:0] IDX_HOLD     = 16'hffe4;
    localparam logic [7:0]  CSR_RESET    = 8'h00;
    localparam logic [15:0] RES_RESET    = 16'h0000;
    localparam logic [7:0]  HOLD_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CSR_DONE = 7;
    localparam int CSR_IE   = 6;
    localparam int CSR_GO   = 5;
    localparam int CSR_SCAN = 4;
    localparam int CSR_CKS  = 3;
    localparam int CSR_GRP  = 2;
    localparam int TEN_BIT  = 0;
    localparam int RES_W    = 10;
    localparam int RES_PAD  = 6;
    localparam int SLOTS    = 4;

    // ------------------------------------------------------------------
    // Timing in states
    // ------------------------------------------------------------------
    localparam int SYNC_MIN_SLOW = 18;
    localparam int SYNC_MAX_SLOW = 33;
    localparam int SYNC_MIN_FAST = 10;
    localparam int SYNC_MAX_FAST = 17;
    localparam int SAMPLE_SLOW   = 63;
    localparam int SAMPLE_FAST   = 31;
    localparam int CONV_MIN_SLOW = 259;
    localparam int CONV_MIN_FAST = 131;
    localparam int NEXT_SLOW     = 256;
    localparam int NEXT_FAST     = 128;
    localparam int STEPS         = 10;
    localparam int STEP_SLOW     = 17;
    localparam int STEP_FAST     = 8;
    localparam int FIN_SLOW      = CONV_MIN_SLOW - SYNC_MIN_SLOW - SAMPLE_SLOW - STEPS * STEP_SLOW;
    localparam int FIN_FAST      = CONV_MIN_FAST - SYNC_MIN_FAST - SAMPLE_FAST - STEPS * STEP_FAST;
    localparam int GAP_SLOW      = NEXT_SLOW - SAMPLE_SLOW - STEPS * STEP_SLOW - FIN_SLOW;
    localparam int GAP_FAST      = NEXT_FAST - SAMPLE_FAST - STEPS * STEP_FAST - FIN_FAST;

    localparam logic [5:0] SYNC_BASE_SLOW = 6'(SYNC_MIN_SLOW);
    localparam logic [5:0] SYNC_BASE_FAST = 6'(SYNC_MIN_FAST);
    localparam logic [3:0] SYNC_SPAN_SLOW = 4'(SYNC_MAX_SLOW - SYNC_MIN_SLOW);
    localparam logic [2:0] SYNC_SPAN_FAST = 3'(SYNC_MAX_FAST - SYNC_MIN_FAST);
    localparam logic [5:0] SAMP_LEN_SLOW  = 6'(SAMPLE_SLOW);
    localparam logic [5:0] SAMP_LEN_FAST  = 6'(SAMPLE_FAST);
    localparam logic [5:0] FIN_LEN_SLOW   = 6'(FIN_SLOW);
    localparam logic [5:0] FIN_LEN_FAST   = 6'(FIN_FAST);
    localparam logic [5:0] GAP_LEN_SLOW   = 6'(GAP_SLOW);
    localparam logic [5:0] GAP_LEN_FAST   = 6'(GAP_FAST);
    localparam logic [4:0] STEP_LEN_SLOW  = 5'(STEP_SLOW);
    localparam logic [4:0] STEP_LEN_FAST  = 5'(STEP_FAST);
    localparam logic [3:0] TOP_BIT        = 4'(STEPS - 1);

    // ------------------------------------------------------------------
    // Sequencer states, Gray along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ACS_IDLE    = 3'b000,
        ACS_SYNC    = 3'b001,
        ACS_SAMPLE  = 3'b011,
        ACS_CONVERT = 3'b010,
        ACS_FINISH  = 3'b110,
        ACS_GAP     = 3'b111
    } acs_state_e;

endpackage : acs_pkg

// *** include/acs_if.sv ***
// Carrier between the sequencer, the approximation engine and the result store.
// Assumes all three parts run on pclk.
`timescale 1ns/100ps
interface acs_if;
    logic        ce;
    logic        start;
    logic        abort;
    logic [4:0]  step_len;
    logic        cmp;
    logic        sar_done;
    logic [9:0]  sar_result;
    logic [9:0]  sar_trial;
    logic        clr;
    logic        wr_en;
    logic [1:0]  wr_slot;
    logic [15:0] wr_data;
    logic [1:0]  rd_slot;
    logic [15:0] rd_data;

    modport ctl (output ce, start, abort, step_len, cmp, clr, wr_en, wr_slot, wr_data, rd_slot,
                 input sar_done, sar_result, sar_trial, rd_data);
    modport sar (input ce, start, abort, step_len, cmp, output sar_done, sar_result, sar_trial);
    modport mem (input ce, clr, wr_en, wr_slot, wr_data, rd_slot, output rd_data);
endinterface : acs_if

// *** logic/acs_result_mem.sv ***
// Four result words with a registered read port.
// Assumes the sequencer drives the write port and the bus drives the read slot.
`timescale 1ns/100ps
module acs_result_mem
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    acs_if.mem       m
);
    logic [15:0] word [SLOTS];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word[i] <= RES_RESET;
            end else if (m.ce) begin
                if (m.clr) begin
                    word[i] <= RES_RESET;
                end else if (m.wr_en && (m.wr_slot == 2'(i))) begin
                    word[i] <= m.wr_data;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m.rd_data <= RES_RESET;
        end else if (m.ce) begin
            m.rd_data <= word[m.rd_slot];
        end
    end
endmodule : acs_result_mem

// *** logic/acs_sar.sv ***
// Successive-approximation engine: one trial bit per step, MSB first.
// Assumes the comparator input is already synchronised.
`timescale 1ns/100ps
module acs_sar
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    acs_if.sar       s
);
    logic       busy;
    logic [3:0] bit_idx;
    logic [4:0] tcnt;
    logic [9:0] acc;

    wire  [9:0] mask  = 10'h001 << bit_idx;
    wire  [9:0] trial = acc | mask;

    assign s.sar_result = acc;
    assign s.sar_trial  = busy ? trial : acc;

    // ------------------------------------------------------------------
    // Step engine
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy       <= 1'b0;
            bit_idx    <= 4'h0;
            tcnt       <= 5'h00;
            acc        <= 10'h000;
            s.sar_done <= 1'b0;
        end else if (s.ce) begin
            s.sar_done <= 1'b0;
            if (s.abort) begin
                busy <= 1'b0;
            end else if (s.start) begin
                busy    <= 1'b1;
                acc     <= 10'h000;
                bit_idx <= TOP_BIT;
                tcnt    <= s.step_len;
            end else if (busy) begin
                if (tcnt == 5'h01) begin
                    if (s.cmp) begin
                        acc <= trial;
                    end
                    tcnt <= s.step_len;
                    if (bit_idx == 4'h0) begin
                        busy       <= 1'b0;
                        s.sar_done <= 1'b1;
                    end else begin
                        bit_idx <= bit_idx - 4'h1;
                    end
                end else begin
                    tcnt <= tcnt - 5'h01;
                end
            end
        end
    end
endmodule : acs_sar

// *** tb/acs_checker.sv ***
// Concurrent checks on the conversion sequencer ports.
// Assumes pclk as the only clock and ce held high.
`timescale 1ns/100ps
module acs_checker
    import acs_pkg::*;
(
    input wire logic pclk, presetn, ce, psel, penable, pwrite, standby, cmp_in, xfer_ack,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic pready, pslverr, sample_hold, converting, conversion_done_request, xfer_request,
    input wire logic [9:0] dac_code,
    input wire logic [2:0] input_sel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int samp_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) samp_cnt <= 0;
        else samp_cnt <= sample_hold ? samp_cnt + 1 : 0;
    end
    sequence samp_end;
        $fell(sample_hold) && converting;
    endsequence
    property steps_follow;
        samp_end |-> converting [*8];
    endproperty
    pready_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("bad wait state");
    ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    req_route_a: assert property (!(conversion_done_request && xfer_request))
        else $error("request on both routes");
    sample_len_a: assert property (samp_end |-> samp_cnt == SAMPLE_SLOW || samp_cnt == SAMPLE_FAST)
        else $error("sampling window length");
    sync_min_a: assert property ($rose(converting) |-> !sample_hold [*8])
        else $error("sampling before sync delay");
    sel_stable_a: assert property (sample_hold [*2] |-> $stable(input_sel)) else $error("input moved");
    xfer_clear_a: assert property (xfer_ack && xfer_request |-> ##[1:3] !xfer_request)
        else $error("service left flag set");
    steps_after_a: assert property (steps_follow) else $error("no steps after sampling");
endmodule : acs_checker
bind acs_top acs_checker i_acs_checker (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .standby, .cmp_in,
    .xfer_ack, .paddr, .pwdata, .prdata, .pstrb, .pready, .pslverr, .sample_hold, .converting,
    .conversion_done_request, .xfer_request, .dac_code, .input_sel);

// *** tb/acs_partner.sv ***
// Comparator and transfer controller facing the sequencer.
// Assumes level is the digital code of the selected input.
`timescale 1ns/100ps
module acs_partner (
    input  wire logic       pclk, presetn, xfer_request,
    input  wire logic [9:0] dac_code, level,
    output logic            cmp_in, xfer_ack
);
    logic busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_in <= 1'b0;
            xfer_ack <= 1'b0;
            busy <= 1'b0;
        end else begin
            cmp_in <= level >= dac_code;
            xfer_ack <= xfer_request && !busy;
            busy <= xfer_request;
        end
    end
endmodule : acs_partner

// *** tb/test_acs_top.sv ***
// Self-checking bench for the conversion sequencer.
// Assumes the partner model answers comparator and service requests.
`timescale 1ns/100ps
module test_acs_top;
    import acs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby = 0, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, cmp_in, xfer_ack, converting, sample_hold, done_req, xfer_req;
    logic [9:0] dac_code;
    logic [2:0] input_sel;
    int num_errors = 0, n_compared = 0, cyc = 0;
    function automatic logic [9:0] code(input logic [2:0] ch);
        return 10'(ch) * 10'd113 + 10'd29;
    endfunction : code
    always #5 pclk = ~pclk;
    acs_top i_acs_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .standby, .cmp_in, .xfer_ack, .dac_code, .sample_hold,
        .input_sel, .converting, .conversion_done_request(done_req), .xfer_request(xfer_req));
    acs_partner i_acs_partner (.pclk, .presetn, .xfer_request(xfer_req), .dac_code,
        .level(code(input_sel)), .cmp_in, .xfer_ack);
    task automatic give_verdict;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict;
        end
    end
    task automatic check(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic single_run(input logic [7:0] csr, input logic [15:0] idx, input int lo, hi);
        int t;
        apb(1, IDX_CSR, csr);
        t = cyc;
        while (done_req !== 1'b1) @(posedge pclk);
        check(cyc - t >= lo + 2 && cyc - t <= hi + 2, 1);
        apb(1, IDX_CSR, csr & 8'h5f);
        apb(0, IDX_CSR, 0);
        check(rd, (csr & 8'hdf) | 8'h80);
        apb(0, idx, 0);
        check(rd, {code(csr[2:0]), 6'h00});
        apb(0, IDX_HOLD, 0);
        check(rd, {24'h000000, 8'(code(csr[2:0]) << 6)});
        apb(1, IDX_CSR, csr & 8'h5f | 8'h80);
        apb(0, IDX_CSR, 0);
        check(rd[7], 1'b1);
        apb(1, IDX_CSR, csr & 8'h5f);
        apb(0, IDX_CSR, 0);
        check(rd, csr & 8'h5f);
        check(done_req, 1'b0);
    endtask : single_run
    task automatic scan_run;
        int t;
        apb(1, IDX_TEN, 1);
        apb(1, IDX_CSR, 8'h7a);
        while (xfer_req !== 1'b1) @(posedge pclk);
        t = cyc;
        check(done_req, 1'b0);
        while (xfer_req !== 1'b0) @(posedge pclk);
        while (xfer_req !== 1'b1) @(posedge pclk);
        check(cyc - t, 3 * NEXT_FAST);
        apb(0, IDX_CSR, 0);
        check(rd, 8'h7a);
        for (int i = 0; i < 4; i++) begin
            apb(0, IDX_RES_BASE + 16'(i), 0);
            check(rd, i < 3 ? {code(3'(i)), 6'h00} : 32'h0);
        end
        repeat (60) @(posedge pclk);
        apb(1, IDX_CSR, 8'h18);
        repeat (3) @(posedge pclk);
        check(converting, 1'b0);
        apb(1, IDX_TEN, 0);
    endtask : scan_run
    task automatic standby_run;
        apb(1, IDX_CSR, 8'h25);
        repeat (200) @(posedge pclk);
        apb(0, IDX_CSR, 0);
        check(rd, 8'h25);
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
        repeat (2) @(posedge pclk);
        check(converting, 1'b0);
        apb(0, IDX_CSR, 0);
        check(rd, 0);
        apb(0, IDX_RES_BASE, 0);
        check(rd, 0);
    endtask : standby_run
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, IDX_CSR, 0);
        check(rd, CSR_RESET);
        apb(0, 16'h0100, 0);
        check(err, 1'b1);
        single_run(8'h61, IDX_RES_BASE + 16'h1, CONV_MIN_SLOW, 274);
        single_run(8'h6e, IDX_RES_BASE + 16'h2, CONV_MIN_FAST, 138);
        scan_run;
        standby_run;
        give_verdict;
    end
endmodule : test_acs_top
